/* rtl/slf_forward.sv */
`timescale 1ns/100ps
// Functional notes
// - forwarded load waits for store data in buffer
// - unrelated loads never stall on pending stores
// - narrow load at store start gets forwarded
// - nonzero offset inside wider store blocks load
// - forwardable younger load passes blocked older loads
// - load spanning several stores is not forwarded
// - wide load over small stores waits for memory
// - offset narrow loads wait for store commit
// - missing store data delays dependent load
// - predict dependent loads; premature issue replays
// - stores leave buffer only after retirement
// - forward needs equal start and containment
module slf_forward
  import slf_pkg::*;
#(
  parameter int DEPTH = slf_pkg::SLF_SQ_DEPTH,
  parameter int LQ = slf_pkg::SLF_LQ_DEPTH,
  parameter int PE = slf_pkg::SLF_PRED_ENTRIES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // store allocate (program order)
  input wire logic stAllocValid,
  input wire logic [slf_pkg::SLF_ADDR_W-1:0] stAllocAddr,
  input wire logic [slf_pkg::SLF_SIZE_W-1:0] stAllocSize,
  // store data produced
  input wire logic stDataValid,
  input wire logic [$clog2(slf_pkg::SLF_SQ_DEPTH)-1:0] stDataIdx,
  input wire logic [slf_pkg::SLF_DATA_W-1:0] stDataValue,
  // retirement and cache write
  input wire logic stRetire,
  input wire logic cacheWrReady,
  output logic cacheWrValid,
  output logic [slf_pkg::SLF_ADDR_W-1:0] cacheWrAddr,
  output logic [slf_pkg::SLF_SIZE_W-1:0] cacheWrSize,
  output logic [slf_pkg::SLF_DATA_W-1:0] cacheWrData,
  output logic stFull,
  // load issue
  input wire logic ldValid,
  input wire logic [slf_pkg::SLF_ADDR_W-1:0] ldAddr,
  input wire logic [slf_pkg::SLF_SIZE_W-1:0] ldSize,
  input wire logic [slf_pkg::SLF_ADDR_W-1:0] ldPc,
  output logic ldReady,
  output logic ldPredictWait,
  // load answer
  output logic ldDoneValid,
  output logic ldDoneFwd,
  output logic ldDoneReplay,
  output logic [slf_pkg::SLF_ADDR_W-1:0] ldDoneAddr,
  output logic [slf_pkg::SLF_DATA_W-1:0] ldDoneData
);
  import slf_pkg::*;
  localparam int IW = $clog2(DEPTH);
  localparam int LW = $clog2(LQ);
  localparam int PW = $clog2(PE);

  // ==========================================
  // store buffer
  logic [DEPTH-1:0] sbValid_reg;
  logic [DEPTH-1:0] sbHasData_reg;
  logic [DEPTH-1:0] sbRetired_reg;
  logic [DEPTH-1:0][SLF_ADDR_W-1:0] sbAddr_reg;
  logic [DEPTH-1:0][SLF_SIZE_W-1:0] sbSize_reg;
  logic [DEPTH-1:0][SLF_DATA_W-1:0] sbData_reg;
  logic [IW-1:0] head_reg;
  logic [IW-1:0] tail_reg;
  logic [IW-1:0] retPtr_reg;

  wire headGo = sbValid_reg[head_reg] & sbRetired_reg[head_reg] & sbHasData_reg[head_reg];
  wire commit = headGo & cacheWrReady;
  // slot freed this cycle; parked loads must forget it before it is reused
  wire [DEPTH-1:0] freeMask = {{(DEPTH-1){1'b0}}, commit} << head_reg;
  wire doAlloc = stAllocValid & ~sbValid_reg[tail_reg];
  wire doRetire = stRetire & sbValid_reg[retPtr_reg] & ~sbRetired_reg[retPtr_reg];

  // ==========================================
  // load wait queue
  logic [LQ-1:0] lqValid_reg;
  logic [LQ-1:0][SLF_ADDR_W-1:0] lqAddr_reg;
  logic [LQ-1:0][SLF_SIZE_W-1:0] lqSize_reg;
  logic [LQ-1:0][SLF_ADDR_W-1:0] lqPc_reg;
  logic [LQ-1:0][DEPTH-1:0] lqOlder_reg;
  slf_match_e lqRes [LQ];
  logic [LQ-1:0][IW-1:0] lqSrc;
  logic [LQ-1:0] lqGo;
  logic [LQ-1:0] lqReplay;

  // ==========================================
  // dependence predictor
  logic [PE-1:0][1:0] pred_reg;
  wire [PW-1:0] ldPidx = ldPc[PW+1:2];
  assign ldPredictWait = pred_reg[ldPidx] != SLF_PRED_RESET;

  // new load matching
  slf_match_e newRes;
  logic [IW-1:0] newSrc;
  slf_store_match #(.DEPTH(DEPTH), .IW(IW)) uNew (
    .stValid(sbValid_reg), .stOlder(sbValid_reg), .stAddr(sbAddr_reg),
    .stSize(sbSize_reg), .ldAddr(ldAddr), .ldSize(ldSize), .headIdx(head_reg),
    .result(newRes), .srcIdx(newSrc)
  );
  wire newFwdNow = (newRes == SLF_FWD) & sbHasData_reg[newSrc];
  wire newDone = (newRes == SLF_NONE) | newFwdNow;

  genvar q;
  generate
    for (q = 0; q < LQ; q++) begin : gLq
      slf_store_match #(.DEPTH(DEPTH), .IW(IW)) uLq (
        .stValid(sbValid_reg), .stOlder(lqOlder_reg[q]), .stAddr(sbAddr_reg),
        .stSize(sbSize_reg), .ldAddr(lqAddr_reg[q]), .ldSize(lqSize_reg[q]),
        .headIdx(head_reg), .result(lqRes[q]), .srcIdx(lqSrc[q])
      );
      // blocked loads proceed once overlapping stores reached memory
      assign lqGo[q] = lqValid_reg[q] & ((lqRes[q] == SLF_NONE) |
        ((lqRes[q] == SLF_FWD) & sbHasData_reg[lqSrc[q]]));
      assign lqReplay[q] = lqRes[q] == SLF_FWD;
    end
  endgenerate

  // pick any ready waiting load, lowest slot; order among waiters free
  logic [LW-1:0] pick;
  logic anyGo;
  logic [LW-1:0] freeSlot;
  logic anyFree;
  always_comb begin
    pick = '0;
    anyGo = 1'b0;
    freeSlot = '0;
    anyFree = 1'b0;
    for (int i = LQ - 1; i >= 0; i--) begin
      if (lqGo[i]) begin
        pick = LW'(i);
        anyGo = 1'b1;
      end
      if (!lqValid_reg[i]) begin
        freeSlot = LW'(i);
        anyFree = 1'b1;
      end
    end
  end

  // new load takes priority so it can pass blocked ones
  wire newTake = ldValid & newDone;
  wire newPark = ldValid & ~newDone & anyFree;
  wire drainLq = anyGo & ~newTake;
  assign ldReady = newDone | anyFree;

  // ==========================================
  // store buffer update
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sbValid_reg <= '0;
      sbHasData_reg <= '0;
      sbRetired_reg <= '0;
      head_reg <= '0;
      tail_reg <= '0;
      retPtr_reg <= '0;
    end else begin
      if (doAlloc) begin
        sbValid_reg[tail_reg] <= 1'b1;
        sbHasData_reg[tail_reg] <= 1'b0;
        sbRetired_reg[tail_reg] <= 1'b0;
        tail_reg <= IW'(tail_reg + 1'b1);
      end
      if (stDataValid) begin
        sbHasData_reg[stDataIdx] <= 1'b1;
      end
      if (doRetire) begin
        sbRetired_reg[retPtr_reg] <= 1'b1;
        retPtr_reg <= IW'(retPtr_reg + 1'b1);
      end
      if (commit) begin
        sbValid_reg[head_reg] <= 1'b0;
        head_reg <= IW'(head_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (doAlloc) begin
      sbAddr_reg[tail_reg] <= stAllocAddr;
      sbSize_reg[tail_reg] <= stAllocSize;
    end
    if (stDataValid) begin
      sbData_reg[stDataIdx] <= stDataValue;
    end
  end

  // ==========================================
  // load queue and predictor update
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lqValid_reg <= '0;
      pred_reg <= '0;
    end else begin
      if (drainLq) begin
        lqValid_reg[pick] <= 1'b0;
        if (lqReplay[pick] && pred_reg[lqPc_reg[pick][PW+1:2]] != SLF_PRED_SAT) begin
          pred_reg[lqPc_reg[pick][PW+1:2]] <= 2'(pred_reg[lqPc_reg[pick][PW+1:2]] + 2'h1);
        end
      end
      if (newPark) begin
        lqValid_reg[freeSlot] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < LQ; i++) begin
      lqOlder_reg[i] <= lqOlder_reg[i] & ~freeMask;
    end
    if (newPark) begin
      lqAddr_reg[freeSlot] <= ldAddr;
      lqSize_reg[freeSlot] <= ldSize;
      lqPc_reg[freeSlot] <= ldPc;
      lqOlder_reg[freeSlot] <= sbValid_reg & ~freeMask;
    end
  end

  // ==========================================
  // output registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ldDoneValid <= 1'b0;
      ldDoneFwd <= 1'b0;
      ldDoneReplay <= 1'b0;
      ldDoneAddr <= '0;
      ldDoneData <= '0;
      cacheWrValid <= 1'b0;
      cacheWrAddr <= '0;
      cacheWrSize <= '0;
      cacheWrData <= '0;
      stFull <= 1'b0;
    end else begin
      ldDoneValid <= newTake | drainLq;
      ldDoneFwd <= newTake ? newFwdNow : (drainLq & lqRes[pick] == SLF_FWD);
      ldDoneReplay <= ~newTake & drainLq & lqReplay[pick];
      ldDoneAddr <= newTake ? ldAddr : lqAddr_reg[pick];
      ldDoneData <= newTake ? (newFwdNow ? sbData_reg[newSrc] : '0)
                            : ((lqRes[pick] == SLF_FWD) ? sbData_reg[lqSrc[pick]] : '0);
      cacheWrValid <= commit;
      cacheWrAddr <= sbAddr_reg[head_reg];
      cacheWrSize <= sbSize_reg[head_reg];
      cacheWrData <= sbData_reg[head_reg];
      stFull <= &((sbValid_reg & ~freeMask) | ({{(DEPTH-1){1'b0}}, doAlloc} << tail_reg));
    end
  end
endmodule : slf_forward

/* rtl/slf_pkg.sv */
package slf_pkg;
  localparam int SLF_ADDR_W = 32;
  localparam int SLF_DATA_W = 64;
  localparam int SLF_BYTES = 8;
  localparam int SLF_SIZE_W = 4;
  localparam int SLF_SQ_DEPTH = 8;
  localparam int SLF_LQ_DEPTH = 4;
  localparam int SLF_PRED_ENTRIES = 16;
  localparam logic [1:0] SLF_PRED_RESET = 2'h0;
  localparam logic [1:0] SLF_PRED_SAT = 2'h3;
  typedef enum logic [1:0] {SLF_NONE, SLF_FWD, SLF_BLOCK} slf_match_e;
endpackage : slf_pkg

/* rtl/slf_store_match.sv */
`timescale 1ns/100ps
// compares one load against all store buffer entries, picks youngest older
module slf_store_match
  import slf_pkg::*;
#(
  parameter int DEPTH = slf_pkg::SLF_SQ_DEPTH,
  parameter int IW = $clog2(slf_pkg::SLF_SQ_DEPTH)
) (
  input wire logic [DEPTH-1:0] stValid,
  input wire logic [DEPTH-1:0] stOlder,
  input wire logic [DEPTH-1:0][slf_pkg::SLF_ADDR_W-1:0] stAddr,
  input wire logic [DEPTH-1:0][slf_pkg::SLF_SIZE_W-1:0] stSize,
  input wire logic [slf_pkg::SLF_ADDR_W-1:0] ldAddr,
  input wire logic [slf_pkg::SLF_SIZE_W-1:0] ldSize,
  input wire logic [IW-1:0] headIdx,
  output slf_pkg::slf_match_e result,
  output logic [IW-1:0] srcIdx
);
  import slf_pkg::*;
  logic [DEPTH-1:0] overlap;
  logic [DEPTH-1:0] canFwd;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gCmp
      wire [SLF_ADDR_W:0] ldEnd = {1'b0, ldAddr} + {{(SLF_ADDR_W-3){1'b0}}, ldSize};
      wire [SLF_ADDR_W:0] stEnd = {1'b0, stAddr[g]} + {{(SLF_ADDR_W-3){1'b0}}, stSize[g]};
      wire live = stValid[g] & stOlder[g];
      assign overlap[g] = live & ({1'b0, ldAddr} < stEnd) & ({1'b0, stAddr[g]} < ldEnd);
      // same start and load fully inside store
      assign canFwd[g] = overlap[g] & (ldAddr == stAddr[g]) & (ldSize <= stSize[g]);
    end
  endgenerate
  // scan from oldest to youngest; last overlapping wins (youngest older store)
  always_comb begin
    logic [IW-1:0] idx;
    logic found;
    logic fwd;
    idx = '0;
    found = 1'b0;
    fwd = 1'b0;
    srcIdx = '0;
    for (int i = 0; i < DEPTH; i++) begin
      idx = IW'(headIdx + IW'(i));
      if (overlap[idx]) begin
        found = 1'b1;
        fwd = canFwd[idx];
        srcIdx = idx;
      end
    end
    if (!found) begin
      result = SLF_NONE;
    end else if (fwd) begin
      result = SLF_FWD;
    end else begin
      result = SLF_BLOCK;
    end
  end
endmodule : slf_store_match

/* verif/slf_forward_assertions.sv */
`timescale 1ns/100ps
// ==========
// forwarding checker
module slf_forward_checker
  import slf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic stAllocValid,
  input wire logic stDataValid,
  input wire logic stRetire,
  input wire logic stFull,
  input wire logic cacheWrValid,
  input wire logic ldValid,
  input wire logic ldReady,
  input wire logic ldDoneValid,
  input wire logic ldDoneFwd,
  input wire logic [slf_pkg::SLF_DATA_W-1:0] ldDoneData
);
  logic [3:0] occ_reg, pend_reg, outst_reg;
  logic seen_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      occ_reg <= 4'h0;
      pend_reg <= 4'h0;
      outst_reg <= 4'h0;
      seen_reg <= 1'b0;
    end else begin
      occ_reg <= occ_reg + 4'(stAllocValid & ~stFull) - 4'(cacheWrValid);
      pend_reg <= pend_reg + 4'(stRetire) - 4'(cacheWrValid);
      outst_reg <= outst_reg + 4'(ldValid & ldReady) - 4'(ldDoneValid);
      seen_reg <= seen_reg | stDataValid;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  reset_quiet_a:
    assert property ($rose(rst_b) |-> !ldDoneValid && !cacheWrValid && !stFull)
    else $error("outputs active after reset");
  unrelated_load_a:
    assert property (ldValid && ldReady && occ_reg == 4'h0 && !stAllocValid
      |=> ldDoneValid && !ldDoneFwd) else $error("unrelated load delayed");
  commit_retired_a:
    assert property (cacheWrValid |-> pend_reg != 4'h0) else $error("write before retire");
  data_seen_a:
    assert property (ldDoneValid && ldDoneFwd |-> seen_reg) else $error("forward without data");
  fwd_source_a:
    assert property (ldDoneValid && ldDoneFwd |-> occ_reg != 4'h0) else $error("no store source");
  done_cause_a:
    assert property (ldDoneValid |-> outst_reg != 4'h0) else $error("answer without load");
  clean_data_a:
    assert property (ldDoneValid && !ldDoneFwd |-> ldDoneData == '0) else $error("stale data");
  ready_full_a:
    assert property (!ldReady |-> outst_reg >= 4'h4) else $error("load refused early");
endmodule : slf_forward_checker

bind slf_forward slf_forward_checker chk_u (.*);

/* verif/slf_cache_model.sv */
`timescale 1ns/100ps
// ==========
// cache write side, optionally slow
module slf_cache_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic cacheWrValid,
  input wire logic [31:0] cacheWrAddr,
  input wire logic [3:0] cacheWrSize,
  input wire logic [63:0] cacheWrData,
  output logic cacheWrReady = 1'b0,
  output logic [7:0] wrCount = 8'h00,
  output logic [31:0] lastAddr = 32'h0000_0000,
  output logic [3:0] lastSize = 4'h0,
  output logic [63:0] lastData = 64'h0000_0000_0000_0000
);
  logic [1:0] phase = 2'h0;
  // ready moves on the edge so the slow flag never races it
  always @(posedge core_clk) begin
    phase <= phase + 2'h1;
    cacheWrReady <= !slow || phase == 2'h3;
  end
  always @(posedge core_clk) begin
    if (cacheWrValid) begin
      wrCount <= wrCount + 8'h01;
      lastAddr <= cacheWrAddr;
      lastSize <= cacheWrSize;
      lastData <= cacheWrData;
    end
  end
endmodule : slf_cache_model

/* verif/testbench.sv */
`timescale 1ns/100ps
// ==========
// forwarding bench
module testbench;
  import slf_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, stAllocValid = 1'b0, stDataValid = 1'b0;
  logic stRetire = 1'b0, ldValid = 1'b0, slow = 1'b0, cacheWrReady, cacheWrValid, stFull;
  logic ldReady, ldPredictWait, ldDoneValid, ldDoneFwd, ldDoneReplay;
  logic [31:0] stAllocAddr = '0, ldAddr = '0, ldPc = '0, cacheWrAddr, ldDoneAddr;
  logic [3:0] stAllocSize = '0, ldSize = '0, cacheWrSize;
  logic [63:0] stDataValue = '0, cacheWrData, ldDoneData;
  logic [2:0] stDataIdx = '0, tl = '0;
  logic [7:0] wr;
  logic [31:0] wrAddr;
  logic [3:0] wrSize;
  logic [63:0] wrData;
  int errors = 0, checked = 0;
  slf_forward dut_u (.*);
  slf_cache_model cache_u (.core_clk(core_clk), .slow(slow), .cacheWrValid(cacheWrValid),
    .cacheWrAddr(cacheWrAddr), .cacheWrSize(cacheWrSize), .cacheWrData(cacheWrData),
    .cacheWrReady(cacheWrReady), .wrCount(wr), .lastAddr(wrAddr), .lastSize(wrSize),
    .lastData(wrData));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic dat(input logic [2:0] ix, input logic [63:0] d);
    stDataValid = 1'b1;
    stDataIdx = ix;
    stDataValue = d;
    @(negedge core_clk);
    stDataValid = 1'b0;
  endtask : dat
  task automatic st(input logic [31:0] a, input logic [3:0] s, input logic [63:0] d);
    stAllocValid = 1'b1;
    stAllocAddr = a;
    stAllocSize = s;
    @(negedge core_clk);
    stAllocValid = 1'b0;
    if (d != '0) dat(tl, d);
    tl++;
  endtask : st
  task automatic ld(input logic [31:0] a, input logic [3:0] s, output logic dn);
    ldValid = 1'b1;
    ldAddr = a;
    ldPc = a;
    ldSize = s;
    #1;
    chk(ldReady, 1'b1);
    @(negedge core_clk);
    dn = ldDoneValid;
    if (dn === 1'b1) chk(ldDoneAddr, a);
  endtask : ld
  task automatic rest(input int n);
    ldValid = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask : rest
  task automatic ret(input int n);
    stRetire = 1'b1;
    repeat (n) @(negedge core_clk);
    stRetire = 1'b0;
  endtask : ret
  task automatic wait_done(input logic fwd, input logic [7:0] d);
    int k;
    k = 0;
    while (ldDoneValid !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    chk({ldDoneValid, ldDoneFwd, ldDoneData[7:0]}, {1'b1, fwd, d});
    chk(ldDoneReplay, fwd);
    @(negedge core_clk);
  endtask : wait_done
  task automatic fwd_case;
    logic dn;
    st(32'h0000_0100, 4'h4, 64'h1111_1111);
    st(32'h0000_0100, 4'h4, 64'h2222_2222);
    ld(32'h0000_0100, 4'h1, dn);
    chk({dn, ldDoneFwd, ldDoneData[7:0]}, 10'h322);
    ld(32'h0000_0101, 4'h1, dn);
    chk(dn, 1'b0);
    ld(32'h0000_0100, 4'h1, dn);
    chk({dn, ldDoneFwd}, 2'h3);
    ld(32'h0000_0200, 4'h4, dn);
    chk({dn, ldDoneFwd}, 2'h2);
    rest(3);
    chk(wr, 8'h00);
    ret(2);
    wait_done(1'b0, 8'h00);
    rest(2);
    chk(wr, 8'h02);
  endtask : fwd_case
  task automatic data_case;
    logic dn;
    logic [2:0] ix;
    ix = tl;
    st(32'h0000_0300, 4'h8, '0);
    ld(32'h0000_0300, 4'h8, dn);
    chk(dn, 1'b0);
    rest(2);
    chk(ldDoneValid, 1'b0);
    dat(ix, 64'h0000_0000_0000_00a5);
    wait_done(1'b1, 8'ha5);
    chk(ldPredictWait, 1'b1);
    slow = 1'b1;
    ret(1);
    rest(12);
    chk(wr, 8'h03);
    chk({wrAddr, wrSize}, {32'h0000_0300, 4'h8});
    chk(wrData, 64'h0000_0000_0000_00a5);
    slow = 1'b0;
  endtask : data_case
  task automatic split_case;
    logic dn;
    st(32'h0000_0400, 4'h4, 64'h0000_0000_0000_0011);
    st(32'h0000_0404, 4'h4, 64'h0000_0000_0000_0022);
    st(32'h0000_0500, 4'h8, 64'h0000_0000_0000_0033);
    ld(32'h0000_0400, 4'h8, dn);
    chk(dn, 1'b0);
    ld(32'h0000_0502, 4'h2, dn);
    chk(dn, 1'b0);
    ld(32'h0000_0504, 4'h2, dn);
    chk(dn, 1'b0);
    rest(1);
    ret(3);
    repeat (3) wait_done(1'b0, 8'h00);
    rest(2);
    chk(wr, 8'h06);
    chk({wrAddr, wrSize}, {32'h0000_0500, 4'h8});
    chk(wrData, 64'h0000_0000_0000_0033);
  endtask : split_case
  task automatic conclude;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    logic dn;
    repeat (2) @(negedge core_clk);
    chk({ldDoneValid, cacheWrValid, stFull}, 3'h0);
    rst_b = 1'b1;
    @(negedge core_clk);
    ld(32'h0000_0040, 4'h4, dn);
    chk(dn, 1'b1);
    chk(ldPredictWait, 1'b0);
    rest(1);
    fwd_case();
    data_case();
    split_case();
    conclude();
  end
  initial begin
    #4000;
    errors++;
    conclude();
  end
endmodule : testbench
